// ---- shared/nsecc_pkg.sv ----
`default_nettype none
// Shared constants and types of the sector code result block
package nsecc_pkg;

    // Page organisation: one code per 512-byte sector, 8-bit words
    localparam int NSECC_SECTOR_BYTES = 512;
    localparam int NSECC_PAGE_BYTES   = 4096;
    localparam int NSECC_SECTORS      = NSECC_PAGE_BYTES / NSECC_SECTOR_BYTES;
    localparam int NSECC_CODE_BYTES   = 3;

    // Field layout of a result register
    localparam int NSECC_BIT_W     = 3;
    localparam int NSECC_WORD_W    = 9;
    localparam int NSECC_POS_W     = NSECC_BIT_W + NSECC_WORD_W;
    localparam int NSECC_CODE_W    = 2 * NSECC_POS_W;
    localparam int NSECC_BIT_LSB   = 0;
    localparam int NSECC_WORD_LSB  = 3;
    localparam int NSECC_CHECK_LSB = 12;

    // Register byte offsets
    localparam int         NSECC_ADDR_W      = 8;
    localparam logic [7:0] NSECC_RESULT_BASE = 8'h00;
    localparam logic [7:0] NSECC_CTRL        = 8'h20;
    localparam logic [7:0] NSECC_FLAGS       = 8'h24;
    localparam logic [7:0] NSECC_IRQ_STAT    = 8'h28;
    localparam logic [7:0] NSECC_IRQ_MASK    = 8'h2C;

    // Control and flag bit positions
    localparam int NSECC_CTRL_TYPE_BIT = 0;
    localparam int NSECC_FLAG_STRIDE   = 3;
    localparam int NSECC_FLAG_REC      = 0;
    localparam int NSECC_FLAG_CODE     = 1;
    localparam int NSECC_FLAG_MULTI    = 2;
    localparam int NSECC_FLAG_GLOBAL   = 24;

    // Interrupt status bits
    localparam int NSECC_IRQ_W      = 3;
    localparam int NSECC_IRQ_DONE   = 0;
    localparam int NSECC_IRQ_SINGLE = 1;
    localparam int NSECC_IRQ_MULTI  = 2;

    // Values after reset
    localparam logic                   NSECC_CTRL_TYPE_RST = 1'b0;
    localparam logic [NSECC_IRQ_W-1:0] NSECC_IRQ_MASK_RST  = 3'h0;
    localparam logic [NSECC_CODE_W-1:0] NSECC_RESULT_RST   = 24'h000000;

    typedef enum logic [1:0] {
        NSECC_IDLE,
        NSECC_MAIN,
        NSECC_SPARE
    } nsecc_phase_e;

    typedef struct packed {
        logic                    rec;
        logic                    code_fault;
        logic                    multi;
        logic [NSECC_CODE_W-1:0] field;
    } nsecc_verdict_s;

endpackage
`default_nettype wire

// ---- verilog/nsecc_sector_code.sv ----
`default_nettype none
// Running position parity of one sector, restarted on its first byte
module nsecc_sector_code
    import nsecc_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clear,
    input  wire logic                    byte_valid,
    input  wire logic [NSECC_WORD_W-1:0] word_addr,
    input  wire logic [7:0]              data_byte,
    output logic      [NSECC_CODE_W-1:0] next_code
);

    logic [NSECC_POS_W-1:0] acc_pos;
    logic                   acc_par;
    logic [NSECC_POS_W-1:0] next_acc_pos;
    logic                   next_acc_par;
    logic [NSECC_POS_W-1:0] base_pos;
    logic                   base_par;

    // XOR of the bit offsets of all set bits in one byte
    function automatic logic [NSECC_BIT_W-1:0] bit_pos_xor(input logic [7:0] d);
        logic [NSECC_BIT_W-1:0] x;
        x = '0;
        for (int j = 0; j < 8; j++) begin
            if (d[j]) begin
                x = x ^ NSECC_BIT_W'(j);
            end
        end
        return x;
    endfunction

    // Accumulate the XOR of positions of ones and the overall parity
    always_comb begin
        base_pos = acc_pos;
        base_par = acc_par;
        if (clear || (byte_valid && word_addr == '0)) begin
            base_pos = '0;
            base_par = 1'b0;
        end
        next_acc_pos = base_pos;
        next_acc_par = base_par;
        if (byte_valid && !clear) begin
            next_acc_pos = base_pos ^ {(^data_byte) ? word_addr : {NSECC_WORD_W{1'b0}},
                                       bit_pos_xor(data_byte)};
            next_acc_par = base_par ^ (^data_byte);
        end
    end

    // Code: inverted zero-side parities on top, position parities below
    assign next_code = {~(next_acc_pos ^ {NSECC_POS_W{next_acc_par}}), next_acc_pos};

    // Accumulator registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_pos <= '0;
            acc_par <= 1'b0;
        end else begin
            acc_pos <= next_acc_pos;
            acc_par <= next_acc_par;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/nsecc_result_regs.sv ----
// Added by the designer: the APB register port and the address map.
`default_nettype none
// Overview of operation
// - Eight result registers, one per 512-byte sector
// - Single error loads bad bit position field
// - Single error loads bad word location field
// - Multiple errors: position fields hold no meaning
// - Second register covers bytes 512 to 1023
// - Recoverable flag plus multiple flag classify errors
// - Sector flags read zero when type zero
// - Code byte error shown one-hot, low 24
module nsecc_result_regs
    import nsecc_pkg::*;
#(
    parameter int SECTORS = NSECC_SECTORS,
    parameter int AW      = NSECC_ADDR_W
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          page_start,
    input  wire logic          page_is_read,
    input  wire logic          flash_byte_valid,
    input  wire logic [7:0]    flash_byte,
    output logic               irq
);

    localparam int SEC_W = $clog2(SECTORS);
    localparam int CNT_W = SEC_W + NSECC_WORD_W;
    localparam logic [NSECC_WORD_W-1:0] LAST_WORD = NSECC_WORD_W'(NSECC_SECTOR_BYTES - 1);
    localparam logic [SEC_W-1:0]        LAST_SEC  = SEC_W'(SECTORS - 1);
    localparam logic [CNT_W-1:0]        LAST_BYTE = CNT_W'(SECTORS * NSECC_SECTOR_BYTES - 1);
    localparam logic [AW-1:0]           RESULT_END = AW'(SECTORS * 4);

    // Page sequencing state
    nsecc_phase_e           phase;
    nsecc_phase_e           next_phase;
    logic [CNT_W-1:0]       byte_cnt;
    logic [CNT_W-1:0]       next_byte_cnt;
    logic                   page_read;
    logic                   next_page_read;
    logic [1:0]             spare_idx;
    logic [1:0]             next_spare_idx;
    logic [SEC_W-1:0]       spare_sec;
    logic [SEC_W-1:0]       next_spare_sec;
    logic [15:0]            spare_buf;
    logic [15:0]            next_spare_buf;

    // Results and per-sector flags
    logic [NSECC_CODE_W-1:0] result      [SECTORS];
    logic [NSECC_CODE_W-1:0] next_result [SECTORS];
    logic [SECTORS-1:0]      flag_rec;
    logic [SECTORS-1:0]      next_flag_rec;
    logic [SECTORS-1:0]      flag_code;
    logic [SECTORS-1:0]      next_flag_code;
    logic [SECTORS-1:0]      flag_multi;
    logic [SECTORS-1:0]      next_flag_multi;

    // Software-visible control and interrupt state
    logic                   type_sel;
    logic                   next_type_sel;
    logic [NSECC_IRQ_W-1:0] irq_stat;
    logic [NSECC_IRQ_W-1:0] next_irq_stat;
    logic [NSECC_IRQ_W-1:0] irq_mask;
    logic [NSECC_IRQ_W-1:0] next_irq_mask;
    logic                   next_irq;

    // Bus answer registers
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;

    // Internal strobes
    logic                    sub_clear;
    logic [NSECC_CODE_W-1:0] sub_code;
    logic [NSECC_CODE_W-1:0] stored_code;
    nsecc_verdict_s          verdict;
    logic [NSECC_IRQ_W-1:0]  events;
    logic [31:0]             rd_data;
    logic                    rd_err;
    logic                    commit;
    logic [SEC_W-1:0]        rd_idx;

    // Compare a stored code with the freshly computed one
    function automatic nsecc_verdict_s judge(input logic [NSECC_CODE_W-1:0] stored,
                                             input logic [NSECC_CODE_W-1:0] comp);
        logic [NSECC_CODE_W-1:0] diff;
        nsecc_verdict_s          v;
        diff = stored ^ comp;
        v    = '0;
        if (diff == '0) begin
            v.field = '0;
        end else if ((diff & (diff - 24'h000001)) == 24'h000000) begin
            v.rec        = 1'b1;
            v.code_fault = 1'b1;
            v.field      = diff;
        end else if ((diff[NSECC_POS_W-1:0] ^ diff[NSECC_CODE_W-1:NSECC_CHECK_LSB]) == 12'hFFF) begin
            v.rec   = 1'b1;
            v.field = {12'h000, diff[NSECC_POS_W-1:NSECC_WORD_LSB],
                       diff[NSECC_WORD_LSB-1:NSECC_BIT_LSB]};
        end else begin
            v.rec   = 1'b1;
            v.multi = 1'b1;
            v.field = diff;
        end
        return v;
    endfunction

    // Shared code accumulator, one sector at a time
    nsecc_sector_code u_code (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (sub_clear),
        .byte_valid (flash_byte_valid && phase == NSECC_MAIN && !page_start),
        .word_addr  (byte_cnt[NSECC_WORD_W-1:0]),
        .data_byte  (flash_byte),
        .next_code  (sub_code)
    );

    // Stored code bytes arrive low byte first after the main area
    assign stored_code = {flash_byte, spare_buf};
    assign verdict     = judge(stored_code, result[spare_sec]);

    // Page sequencing: main area, then stored codes on a read
    always_comb begin
        next_phase      = phase;
        next_byte_cnt   = byte_cnt;
        next_page_read  = page_read;
        next_spare_idx  = spare_idx;
        next_spare_sec  = spare_sec;
        next_spare_buf  = spare_buf;
        next_result     = result;
        next_flag_rec   = flag_rec;
        next_flag_code  = flag_code;
        next_flag_multi = flag_multi;
        sub_clear       = 1'b0;
        events          = '0;
        if (page_start) begin
            next_phase      = NSECC_MAIN;
            next_byte_cnt   = '0;
            next_page_read  = page_is_read;
            next_spare_idx  = 2'h0;
            next_spare_sec  = '0;
            next_flag_rec   = '0;
            next_flag_code  = '0;
            next_flag_multi = '0;
            sub_clear       = 1'b1;
        end else if (flash_byte_valid) begin
            unique case (phase)
                NSECC_IDLE: begin
                    next_phase = NSECC_IDLE;
                end
                NSECC_MAIN: begin
                    next_byte_cnt = byte_cnt + CNT_W'(1);
                    if (byte_cnt[NSECC_WORD_W-1:0] == LAST_WORD) begin
                        // Sector index is the byte count divided by 512
                        next_result[byte_cnt[CNT_W-1:NSECC_WORD_W]] = sub_code;
                    end
                    if (byte_cnt == LAST_BYTE) begin
                        if (page_read) begin
                            next_phase = NSECC_SPARE;
                        end else begin
                            next_phase             = NSECC_IDLE;
                            events[NSECC_IRQ_DONE] = 1'b1;
                        end
                    end
                end
                NSECC_SPARE: begin
                    if (spare_idx == 2'(NSECC_CODE_BYTES - 1)) begin
                        next_result[spare_sec]     = verdict.field;
                        next_flag_rec[spare_sec]   = verdict.rec;
                        next_flag_code[spare_sec]  = verdict.code_fault;
                        next_flag_multi[spare_sec] = verdict.multi;
                        events[NSECC_IRQ_SINGLE]   = verdict.rec && !verdict.multi;
                        events[NSECC_IRQ_MULTI]    = verdict.multi;
                        next_spare_idx             = 2'h0;
                        next_spare_sec             = spare_sec + SEC_W'(1);
                        if (spare_sec == LAST_SEC) begin
                            next_phase             = NSECC_IDLE;
                            events[NSECC_IRQ_DONE] = 1'b1;
                        end
                    end else begin
                        if (spare_idx == 2'h0) begin
                            next_spare_buf[7:0] = flash_byte;
                        end else begin
                            next_spare_buf[15:8] = flash_byte;
                        end
                        next_spare_idx = spare_idx + 2'h1;
                    end
                end
            endcase
        end
    end

    // Page sequencing registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase      <= NSECC_IDLE;
            byte_cnt   <= '0;
            page_read  <= 1'b0;
            spare_idx  <= 2'h0;
            spare_sec  <= '0;
            spare_buf  <= 16'h0000;
            flag_rec   <= '0;
            flag_code  <= '0;
            flag_multi <= '0;
            for (int k = 0; k < SECTORS; k++) begin
                result[k] <= NSECC_RESULT_RST;
            end
        end else begin
            phase      <= next_phase;
            byte_cnt   <= next_byte_cnt;
            page_read  <= next_page_read;
            spare_idx  <= next_spare_idx;
            spare_sec  <= next_spare_sec;
            spare_buf  <= next_spare_buf;
            flag_rec   <= next_flag_rec;
            flag_code  <= next_flag_code;
            flag_multi <= next_flag_multi;
            result     <= next_result;
        end
    end

    // Read decode, error on unmapped, unaligned or read-only write
    assign rd_idx = paddr[SEC_W+1:2];
    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (paddr < RESULT_END) begin
            rd_data = {8'h00, result[rd_idx]};
            rd_err  = pwrite;
        end else if (paddr == AW'(NSECC_CTRL)) begin
            rd_data[NSECC_CTRL_TYPE_BIT] = type_sel;
        end else if (paddr == AW'(NSECC_FLAGS)) begin
            for (int k = 0; k < SECTORS; k++) begin
                rd_data[NSECC_FLAG_STRIDE*k+NSECC_FLAG_REC]   = flag_rec[k] & type_sel;
                rd_data[NSECC_FLAG_STRIDE*k+NSECC_FLAG_CODE]  = flag_code[k] & type_sel;
                rd_data[NSECC_FLAG_STRIDE*k+NSECC_FLAG_MULTI] = flag_multi[k] & type_sel;
            end
            rd_data[NSECC_FLAG_GLOBAL] = (|flag_multi) & type_sel;
            rd_err                     = pwrite;
        end else if (paddr == AW'(NSECC_IRQ_STAT)) begin
            rd_data[NSECC_IRQ_W-1:0] = irq_stat;
        end else if (paddr == AW'(NSECC_IRQ_MASK)) begin
            rd_data[NSECC_IRQ_W-1:0] = irq_mask;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Bus answer one cycle into the access phase; write lands at completion
    assign commit = psel && penable && pready && pwrite && !pslverr;
    always_comb begin
        next_pready   = 1'b0;
        next_prdata   = 32'h00000000;
        next_pslverr  = 1'b0;
        next_type_sel = type_sel;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (psel && penable && !pready) begin
            next_pready  = 1'b1;
            next_prdata  = pwrite ? 32'h00000000 : rd_data;
            next_pslverr = rd_err;
        end
        if (commit && paddr == AW'(NSECC_CTRL)) begin
            next_type_sel = pwdata[NSECC_CTRL_TYPE_BIT];
        end
        if (commit && paddr == AW'(NSECC_IRQ_MASK)) begin
            next_irq_mask = pwdata[NSECC_IRQ_W-1:0];
        end
        if (commit && paddr == AW'(NSECC_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~pwdata[NSECC_IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // Bus and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            type_sel <= NSECC_CTRL_TYPE_RST;
            irq_mask <= NSECC_IRQ_MASK_RST;
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
            type_sel <= next_type_sel;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            irq      <= next_irq;
        end
    end

endmodule
`default_nettype wire

// ---- bench/nsecc_result_regs_assertions.sv ----
`default_nettype none
// Bus timing and flag consistency checks on the result register block
module nsecc_result_regs_assertions
    import nsecc_pkg::*;
#(
    parameter int SECTORS = NSECC_SECTORS,
    parameter int AW      = NSECC_ADDR_W
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          page_start,
    input wire logic          page_is_read,
    input wire logic          flash_byte_valid,
    input wire logic [7:0]    flash_byte,
    input wire logic          irq
);
    logic acc;
    logic rd_ok;
    logic ctrl_q;
    logic next_ctrl_q;
    // First access cycle and a completed good read
    assign acc   = psel && penable && !pready;
    assign rd_ok = pready && psel && penable && !pwrite && !pslverr;
    // Shadow of the correction type bit, so flag reads can be judged
    always_comb begin
        next_ctrl_q = ctrl_q;
        if (pready && pwrite && paddr == NSECC_CTRL && !pslverr) begin
            next_ctrl_q = pwdata[0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 1'b0;
        end else begin
            ctrl_q <= next_ctrl_q;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    wait_state_a: assert property (acc |=> pready)
        else $error("access phase not answered after one wait");
    ready_cause_a: assert property (pready |-> $past(acc))
        else $error("pready without an access");
    idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside a reply");
    ro_write_a: assert property (acc && pwrite && (paddr < 8'h20 || paddr == NSECC_FLAGS) |=> pslverr)
        else $error("write to read-only place accepted");
    result_top_a: assert property (rd_ok && paddr < 8'h20 |-> prdata[31:24] == 8'h00)
        else $error("result upper byte not zero");
    flags_type_a: assert property (rd_ok && paddr == NSECC_FLAGS && !ctrl_q |-> prdata == 32'h0)
        else $error("flags visible with type zero");
    flags_global_a: assert property (rd_ok && paddr == NSECC_FLAGS |-> prdata[24] == |(prdata & 32'h00924924))
        else $error("global multiple flag disagrees");
    multi_rec_a: assert property (rd_ok && paddr == NSECC_FLAGS |-> ((prdata & 32'h00924924) >> 2 & ~prdata) == 0)
        else $error("multiple flag without recoverable flag");
    mask_quiet_a: assert property (pready && pwrite && paddr == NSECC_IRQ_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("interrupt with all sources masked");
    cover property (rd_ok && paddr == NSECC_FLAGS && prdata[24]);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule
bind nsecc_result_regs nsecc_result_regs_assertions #(.SECTORS(SECTORS), .AW(AW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .page_start(page_start),
    .page_is_read(page_is_read), .flash_byte_valid(flash_byte_valid), .flash_byte(flash_byte), .irq(irq));
`default_nettype wire

// ---- bench/nsecc_flash_model.sv ----
`default_nettype none
// Flash device streaming a stored page: main area, then spare codes on reads
module nsecc_flash_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       rd,
    input  wire logic       slow,
    output logic            page_start,
    output logic            page_is_read,
    output logic            flash_byte_valid,
    output logic      [7:0] flash_byte,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4119];
    int         idx;
    int         last;
    logic       ph;
    // One byte a cycle, or every other cycle when slow; idle data toggles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_start       <= 1'b0;
            page_is_read     <= 1'b0;
            flash_byte_valid <= 1'b0;
            flash_byte       <= 8'h00;
            busy             <= 1'b0;
            ph               <= 1'b0;
        end else begin
            page_start       <= 1'b0;
            flash_byte_valid <= 1'b0;
            flash_byte       <= ~flash_byte;
            ph               <= ~ph;
            if (go && !busy) begin
                page_start   <= 1'b1;
                page_is_read <= rd;
                busy         <= 1'b1;
                idx          <= 0;
                last         <= rd ? 4120 : 4096;
            end else if (busy && (!slow || ph)) begin
                flash_byte_valid <= 1'b1;
                flash_byte       <= mem[idx];
                idx              <= idx + 1;
                busy             <= (idx + 1 < last);
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/nsecc_result_regs_tb.sv ----
`default_nettype none
// Bench: write page, code copy to spare, read page with injected faults
module nsecc_result_regs_tb
    import nsecc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        page_start;
    logic        page_is_read;
    logic        flash_byte_valid;
    logic [7:0]  flash_byte;
    logic        irq;
    logic        go = 1'b0;
    logic        rd = 1'b0;
    logic        slow = 1'b0;
    logic        busy;
    logic [31:0] rdata;
    logic        rerr;
    logic [31:0] seed = 32'hFDECB15E;
    logic [31:0] t;
    logic [23:0] exp_res [0:7];
    int          mismatches = 0;
    int          check_count = 0;
    int          cyc = 0;
    nsecc_result_regs #(.SECTORS(8), .AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .page_start(page_start), .page_is_read(page_is_read),
        .flash_byte_valid(flash_byte_valid), .flash_byte(flash_byte), .irq(irq));
    nsecc_flash_model u_flash (.pclk(pclk), .presetn(presetn), .go(go), .rd(rd), .slow(slow),
        .page_start(page_start), .page_is_read(page_is_read), .flash_byte_valid(flash_byte_valid),
        .flash_byte(flash_byte), .busy(busy));
    // Clock and hang limit
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n), 32'h00000002, "answer latency");
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, "read data");
        chk(rerr, err, "read error");
    endtask
    // Run one page through the flash model and wait for its end
    task automatic page(input logic r, input logic s);
        int n;
        rd <= r;
        slow <= s;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 9000);
        repeat (2) @(posedge pclk);
    endtask
    // Code of sector k: position XOR of all one bits, inverted copy, parity
    function automatic logic [23:0] code_of(int k);
        logic [11:0] p;
        logic        par;
        p = 12'h0;
        par = 1'b0;
        for (int w = 0; w < 512; w++) for (int b = 0; b < 8; b++) if (u_flash.mem[512*k+w][b]) begin
            p ^= {w[8:0], b[2:0]};
            par = ~par;
        end
        return {~(p ^ {12{par}}), p};
    endfunction
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) rchk(8'(4*k), 32'h0, 1'b0);
        rchk(NSECC_FLAGS, 32'h0, 1'b0);
        rchk(8'h30, 32'h0, 1'b1);
        rchk(8'h06, 32'h0, 1'b1);
        apb(1'b1, 8'h04, 32'hFFFFFFFF);
        chk(rerr, 1'b1, "ro write");
        rchk(8'h04, 32'h0, 1'b0);
        for (int i = 0; i < 4096; i++) u_flash.mem[i] = 8'($random(seed));
        apb(1'b1, NSECC_IRQ_MASK, 32'h7);
        apb(1'b1, NSECC_CTRL, 32'h1);
        page(1'b0, 1'b0);
        chk(irq, 1'b1, "done irq");
        for (int k = 0; k < 8; k++) begin
            exp_res[k] = code_of(k);
            rchk(8'(4*k), {8'h00, exp_res[k]}, 1'b0);
            for (int j = 0; j < 3; j++) u_flash.mem[4096+3*k+j] = exp_res[k][8*j+:8];
        end
        rchk(NSECC_IRQ_STAT, 32'h1, 1'b0);
        apb(1'b1, NSECC_IRQ_STAT, 32'h1);
        rchk(NSECC_IRQ_STAT, 32'h0, 1'b0);
        chk(irq, 1'b0, "irq cleared");
        // Faults: sector1 last byte, sector2 code bit, sector3 double, sector4 random, sector7 last byte
        t = $random(seed);
        u_flash.mem[1023][t[2:0]] ^= 1'b1;
        u_flash.mem[4102+(t[7:3]%24)/8][(t[7:3]%24)%8] ^= 1'b1;
        u_flash.mem[1536+t[16:8]] ^= 8'h03;
        u_flash.mem[2048+t[25:17]][t[28:26]] ^= 1'b1;
        u_flash.mem[4095][t[31:29]] ^= 1'b1;
        page(1'b1, 1'b1);
        exp_res = '{24'h0, {12'h0, 9'd511, t[2:0]}, 24'h1 << (t[7:3] % 24), 24'h0,
            {12'h0, t[25:17], t[28:26]}, 24'h0, 24'h0, {12'h0, 9'd511, t[31:29]}};
        for (int k = 0; k < 8; k++) if (k != 3) rchk(8'(4*k), {8'h00, exp_res[k]}, 1'b0);
        rchk(NSECC_FLAGS, 32'h01201AC8, 1'b0);
        rchk(NSECC_IRQ_STAT, 32'h7, 1'b0);
        apb(1'b1, NSECC_CTRL, 32'h0);
        rchk(NSECC_FLAGS, 32'h0, 1'b0);
        apb(1'b1, NSECC_IRQ_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0, "masked irq");
        end_sim();
    end
endmodule
`default_nettype wire
